/* logic/shsc_pkg.sv */
// package: register map, field positions and timing for the sdio host control block
`default_nettype none
package shsc_pkg;
    localparam logic [31:0] SHSC_ADDR_HOST_CTRL = 32'h5a000000;
    localparam logic [31:0] SHSC_ADDR_PRESCALER = 32'h5a000004;
    localparam logic [31:0] SHSC_ADDR_CMD_ARG   = 32'h5a000008;
    localparam logic [31:0] SHSC_ADDR_SDIO_CFG  = 32'h5a000040;
    localparam logic [31:0] SHSC_ADDR_SDIO_STAT = 32'h5a000044;

    // host control fields
    localparam int SHSC_CTL_SOFT_RST   = 8;
    localparam int SHSC_CTL_CLK_TYPE   = 5;
    localparam int SHSC_CTL_BYTE_ORD   = 4;
    localparam int SHSC_CTL_IRQ_RCV    = 3;
    localparam int SHSC_CTL_RWAIT_EN   = 2;
    localparam int SHSC_CTL_CLK_OUT_EN = 0;

    // sdio config fields
    localparam int SHSC_CFG_WIDE_BUS   = 0;
    localparam int SHSC_CFG_PRD_TYPE   = 1;

    // sdio status fields
    localparam int SHSC_STAT_CARD_IRQ  = 0;
    localparam int SHSC_STAT_RWAIT_REQ = 1;
    localparam int SHSC_STAT_WIN_OPEN  = 2;

    localparam logic [7:0]  SHSC_PRESCALER_RST = 8'h01;
    localparam logic [31:0] SHSC_CMD_ARG_RST   = 32'h0000_0000;

    // card clocks between packet end and window/read-wait events
    localparam logic [1:0]  SHSC_GAP_CLKS      = 2'h2;

    typedef enum logic [2:0] {
        SHSC_WIN_IDLE,
        SHSC_WIN_DELAY_A,
        SHSC_WIN_SHORT,
        SHSC_WIN_HOLD,
        SHSC_WIN_DELAY_C
    } shsc_win_t;

    typedef enum logic [1:0] {
        SHSC_RW_IDLE,
        SHSC_RW_DELAY,
        SHSC_RW_ACTIVE
    } shsc_rw_t;

    // byte lane picked for transfer step idx under type A or type B order
    function automatic logic [7:0] shsc_pick_byte(input logic [31:0] w,
                                                  input logic [1:0]  idx,
                                                  input logic        half,
                                                  input logic        order_b);
        logic [1:0] lane;
        lane = 2'h0;
        if (half) begin
            lane = order_b ? {1'b0, ~idx[0]} : {1'b0, idx[0]};
        end else begin
            lane = order_b ? ~idx : idx;
        end
        return w[{lane, 3'h0} +: 8];
    endfunction
endpackage
`default_nettype wire

/* logic/shsc_sdio_ctrl.sv */
// sdio interrupt window, read wait, host control, prescaler and argument registers
`timescale 1ns/100ps
`default_nettype none
module shsc_sdio_ctrl
    import shsc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        data_packet_done_i,
    input  wire logic        multi_block_i,
    input  wire logic        last_block_i,
    input  wire logic        multi_read_i,
    input  wire logic        withdata_cmd_end_i,
    input  wire logic        abort_rsp_end_i,
    input  wire logic [31:0] xfer_word_i,
    input  wire logic [1:0]  xfer_idx_i,
    input  wire logic        xfer_half_i,
    output logic      [7:0]  xfer_byte_o,
    input  wire logic        rx_data_line1_i,
    output logic             tx_data_line2_o,
    output logic             tx_data_line2_oe_o,
    output logic             card_clock_o,
    output logic             clock_type_sel_o,
    output logic             block_soft_reset_o,
    output logic      [31:0] cmd_argument_o,
    output logic             card_irq_pending_o
);
    import shsc_pkg::*;

    logic        soft_rst_r;
    logic        clock_type_sel_r;
    logic        byte_order_sel_r;
    logic        card_irq_receive_en_r;
    logic        read_wait_en_r;
    logic        card_clock_out_en_r;
    logic [7:0]  prescaler_r;
    logic [31:0] cmd_argument_r;
    logic        wide_bus_r;
    logic        irq_period_type_r;
    logic        card_irq_flag_r;
    logic [31:0] rdata_r;
    logic [7:0]  div_cnt_r;
    logic [7:0]  div_cnt_nxt;
    logic        card_clock_r;
    logic        dat1_s1_r;
    logic        dat1_s2_r;
    logic        dat1_s3_r;
    logic        dat1_stable_r;
    shsc_win_t   win_state_r;
    logic [1:0]  win_cnt_r;
    logic        last_block_r;
    shsc_rw_t    rw_state_r;
    logic [1:0]  rw_cnt_r;
    logic        tx_line2_oe_r;
    logic        tx_line2_r;
    logic [7:0]  xfer_byte_r;
    logic [7:0]  div_top;
    logic [7:0]  high_len;
    logic [8:0]  high_sum;
    logic        card_tick;
    logic        win_open;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_pre;
    logic        irq_set;
    logic        rw_clear;

    assign wr_ctrl  = wr_i && (addr_i == SHSC_ADDR_HOST_CTRL);
    assign wr_stat  = wr_i && (addr_i == SHSC_ADDR_SDIO_STAT);
    assign wr_pre   = wr_i && (addr_i == SHSC_ADDR_PRESCALER);
    assign rw_clear = wr_stat && wdata_i[SHSC_STAT_RWAIT_REQ];

    // soft reset pulse, self-clearing
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_ctrl && wdata_i[SHSC_CTL_SOFT_RST];
        end
    end

    // host control register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_type_sel_r      <= 1'b0;
            byte_order_sel_r      <= 1'b0;
            card_irq_receive_en_r <= 1'b0;
            read_wait_en_r        <= 1'b0;
            card_clock_out_en_r   <= 1'b0;
        end else if (soft_rst_r) begin
            clock_type_sel_r      <= 1'b0;
            byte_order_sel_r      <= 1'b0;
            card_irq_receive_en_r <= 1'b0;
            read_wait_en_r        <= 1'b0;
            card_clock_out_en_r   <= 1'b0;
        end else if (wr_ctrl) begin
            clock_type_sel_r      <= wdata_i[SHSC_CTL_CLK_TYPE];
            byte_order_sel_r      <= wdata_i[SHSC_CTL_BYTE_ORD];
            card_irq_receive_en_r <= wdata_i[SHSC_CTL_IRQ_RCV];
            read_wait_en_r        <= wdata_i[SHSC_CTL_RWAIT_EN];
            card_clock_out_en_r   <= wdata_i[SHSC_CTL_CLK_OUT_EN];
        end
    end

    // prescaler, argument and sdio config registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prescaler_r       <= SHSC_PRESCALER_RST;
            cmd_argument_r    <= SHSC_CMD_ARG_RST;
            wide_bus_r        <= 1'b0;
            irq_period_type_r <= 1'b0;
        end else if (soft_rst_r) begin
            prescaler_r       <= SHSC_PRESCALER_RST;
            cmd_argument_r    <= SHSC_CMD_ARG_RST;
            wide_bus_r        <= 1'b0;
            irq_period_type_r <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == SHSC_ADDR_PRESCALER) begin
                prescaler_r <= wdata_i[7:0];
            end
            if (addr_i == SHSC_ADDR_CMD_ARG) begin
                cmd_argument_r <= wdata_i;
            end
            if (addr_i == SHSC_ADDR_SDIO_CFG) begin
                wide_bus_r        <= wdata_i[SHSC_CFG_WIDE_BUS];
                irq_period_type_r <= wdata_i[SHSC_CFG_PRD_TYPE];
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= 32'h0000_0000;
            if (rd_i) begin
                unique case (addr_i)
                    SHSC_ADDR_HOST_CTRL: begin
                        rdata_r[SHSC_CTL_CLK_TYPE]   <= clock_type_sel_r;
                        rdata_r[SHSC_CTL_BYTE_ORD]   <= byte_order_sel_r;
                        rdata_r[SHSC_CTL_IRQ_RCV]    <= card_irq_receive_en_r;
                        rdata_r[SHSC_CTL_RWAIT_EN]   <= read_wait_en_r;
                        rdata_r[SHSC_CTL_CLK_OUT_EN] <= card_clock_out_en_r;
                    end
                    SHSC_ADDR_PRESCALER: begin
                        rdata_r[7:0] <= prescaler_r;
                    end
                    SHSC_ADDR_CMD_ARG: begin
                        rdata_r <= cmd_argument_r;
                    end
                    SHSC_ADDR_SDIO_CFG: begin
                        rdata_r[SHSC_CFG_WIDE_BUS] <= wide_bus_r;
                        rdata_r[SHSC_CFG_PRD_TYPE] <= irq_period_type_r;
                    end
                    SHSC_ADDR_SDIO_STAT: begin
                        rdata_r[SHSC_STAT_CARD_IRQ]  <= card_irq_flag_r;
                        rdata_r[SHSC_STAT_RWAIT_REQ] <= (rw_state_r == SHSC_RW_ACTIVE);
                        rdata_r[SHSC_STAT_WIN_OPEN]  <= win_open;
                    end
                    default: begin
                        rdata_r <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // card clock divider; zero prescaler behaves as one
    assign div_top   = (prescaler_r == 8'h00) ? 8'h01 : prescaler_r;
    assign high_sum  = {1'b0, div_top} + 9'h001;
    assign high_len  = high_sum[8:1];
    assign card_tick = card_clock_out_en_r && (div_cnt_r == div_top);

    always_comb begin
        div_cnt_nxt = 8'h00;
        if (card_clock_out_en_r && (div_cnt_r < div_top)) begin
            div_cnt_nxt = div_cnt_r + 8'h01;
        end
    end

    // prescaler write restarts the count so it never sits above a smaller top;
    // high phase follows the current count so the first pulse is full width
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_r    <= 8'h00;
            card_clock_r <= 1'b0;
        end else if (soft_rst_r || !card_clock_out_en_r || wr_pre) begin
            div_cnt_r    <= 8'h00;
            card_clock_r <= 1'b0;
        end else begin
            div_cnt_r    <= div_cnt_nxt;
            card_clock_r <= (div_cnt_r < high_len);
        end
    end

    // data line 1 synchroniser with agreement filter
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dat1_s1_r     <= 1'b1;
            dat1_s2_r     <= 1'b1;
            dat1_s3_r     <= 1'b1;
            dat1_stable_r <= 1'b1;
        end else begin
            dat1_s1_r <= rx_data_line1_i;
            dat1_s2_r <= dat1_s1_r;
            dat1_s3_r <= dat1_s2_r;
            if (dat1_s2_r == dat1_s3_r) begin
                dat1_stable_r <= dat1_s3_r;
            end
        end
    end

    // interrupt detection window
    assign win_open = !wide_bus_r
                      || (win_state_r == SHSC_WIN_SHORT)
                      || (win_state_r == SHSC_WIN_HOLD);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            win_state_r  <= SHSC_WIN_IDLE;
            win_cnt_r    <= 2'h0;
            last_block_r <= 1'b0;
        end else if (soft_rst_r || !wide_bus_r) begin
            win_state_r  <= SHSC_WIN_IDLE;
            win_cnt_r    <= 2'h0;
            last_block_r <= 1'b0;
        end else if (data_packet_done_i) begin
            win_state_r  <= SHSC_WIN_DELAY_A;
            win_cnt_r    <= 2'h0;
            last_block_r <= last_block_i;
        end else if (abort_rsp_end_i && multi_block_i && !irq_period_type_r) begin
            win_state_r <= SHSC_WIN_DELAY_C;
            win_cnt_r   <= 2'h0;
        end else begin
            unique case (win_state_r)
                SHSC_WIN_IDLE: begin
                    win_cnt_r <= 2'h0;
                end
                SHSC_WIN_DELAY_A: begin
                    if (card_tick) begin
                        win_cnt_r <= win_cnt_r + 2'h1;
                        if (win_cnt_r == SHSC_GAP_CLKS - 2'h1) begin
                            win_cnt_r <= 2'h0;
                            if (!multi_block_i) begin
                                win_state_r <= SHSC_WIN_HOLD;
                            end else if (irq_period_type_r && last_block_r) begin
                                win_state_r <= SHSC_WIN_HOLD;
                            end else begin
                                win_state_r <= SHSC_WIN_SHORT;
                            end
                        end
                    end
                end
                SHSC_WIN_SHORT: begin
                    if (card_tick) begin
                        win_cnt_r <= win_cnt_r + 2'h1;
                        if (win_cnt_r == SHSC_GAP_CLKS - 2'h1) begin
                            win_cnt_r   <= 2'h0;
                            win_state_r <= SHSC_WIN_IDLE;
                        end
                    end
                end
                SHSC_WIN_HOLD: begin
                    if (withdata_cmd_end_i) begin
                        win_state_r <= SHSC_WIN_IDLE;
                    end
                end
                SHSC_WIN_DELAY_C: begin
                    if (card_tick) begin
                        win_cnt_r <= win_cnt_r + 2'h1;
                        if (win_cnt_r == SHSC_GAP_CLKS - 2'h1) begin
                            win_cnt_r   <= 2'h0;
                            win_state_r <= SHSC_WIN_HOLD;
                        end
                    end
                end
                default: begin
                    win_state_r <= SHSC_WIN_IDLE;
                end
            endcase
        end
    end

    // sticky card interrupt flag, set wins over clear
    assign irq_set = card_irq_receive_en_r && win_open && !dat1_stable_r;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            card_irq_flag_r <= 1'b0;
        end else if (soft_rst_r) begin
            card_irq_flag_r <= 1'b0;
        end else begin
            card_irq_flag_r <= irq_set || (card_irq_flag_r
                               && !(wr_stat && wdata_i[SHSC_STAT_CARD_IRQ]));
        end
    end

    // read wait request on data line 2
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rw_state_r <= SHSC_RW_IDLE;
            rw_cnt_r   <= 2'h0;
        end else if (soft_rst_r || !read_wait_en_r) begin
            rw_state_r <= SHSC_RW_IDLE;
            rw_cnt_r   <= 2'h0;
        end else begin
            unique case (rw_state_r)
                SHSC_RW_IDLE: begin
                    rw_cnt_r <= 2'h0;
                    if (data_packet_done_i && multi_read_i) begin
                        rw_state_r <= SHSC_RW_DELAY;
                    end
                end
                SHSC_RW_DELAY: begin
                    if (card_tick) begin
                        rw_cnt_r <= rw_cnt_r + 2'h1;
                        if (rw_cnt_r == SHSC_GAP_CLKS - 2'h1) begin
                            rw_state_r <= SHSC_RW_ACTIVE;
                        end
                    end
                end
                SHSC_RW_ACTIVE: begin
                    if (rw_clear) begin
                        rw_state_r <= SHSC_RW_IDLE;
                    end
                end
                default: begin
                    rw_state_r <= SHSC_RW_IDLE;
                end
            endcase
        end
    end

    // line 2 driven low while read wait stands, in either bus width
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_line2_oe_r <= 1'b0;
            tx_line2_r    <= 1'b1;
        end else begin
            tx_line2_oe_r <= (rw_state_r == SHSC_RW_ACTIVE) && !soft_rst_r;
            tx_line2_r    <= 1'b0;
        end
    end

    // byte order for the data path
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xfer_byte_r <= 8'h00;
        end else begin
            xfer_byte_r <= shsc_pick_byte(xfer_word_i, xfer_idx_i, xfer_half_i,
                                          byte_order_sel_r);
        end
    end

    assign rdata_o            = rdata_r;
    assign xfer_byte_o        = xfer_byte_r;
    assign tx_data_line2_o    = tx_line2_r;
    assign tx_data_line2_oe_o = tx_line2_oe_r;
    assign card_clock_o       = card_clock_r;
    assign clock_type_sel_o   = clock_type_sel_r;
    assign block_soft_reset_o = soft_rst_r;
    assign cmd_argument_o     = cmd_argument_r;
    assign card_irq_pending_o = card_irq_flag_r;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence soft_reset_write_s;
        wr_ctrl && wdata_i[SHSC_CTL_SOFT_RST];
    endsequence

    sequence block_cleared_s;
        soft_rst_r ##1 (!soft_rst_r && !card_clock_out_en_r
                        && cmd_argument_r == 32'h0000_0000 && prescaler_r == 8'h01);
    endsequence

    irq_gate_en_a: assert property ($rose(card_irq_flag_r) |-> $past(card_irq_receive_en_r))
        else $error("card interrupt set while receive disabled");
    rwait_gate_en_a: assert property ($rose(tx_line2_oe_r) |-> $past(read_wait_en_r, 2))
        else $error("read wait driven while disabled");
    one_line_open_a: assert property (!wide_bus_r |-> win_open)
        else $error("window closed in one-line mode");
    irq_window_only_a: assert property ($rose(card_irq_flag_r) |-> $past(win_open))
        else $error("interrupt taken outside window");
    short_window_len_a: assert property (
        win_state_r == SHSC_WIN_SHORT && card_tick && win_cnt_r == 2'h1
        && !data_packet_done_i && !abort_rsp_end_i && wide_bus_r && !soft_rst_r
        |=> win_state_r == SHSC_WIN_IDLE)
        else $error("short window not closed after two card clocks");
    soft_reset_clear_a: assert property (soft_reset_write_s |=> block_cleared_s)
        else $error("soft reset did not clear block or self-clear");
    clock_gate_off_a: assert property (!card_clock_out_en_r |=> !card_clock_r)
        else $error("card clock running while disabled");
    arg_write_a: assert property (wr_i && addr_i == SHSC_ADDR_CMD_ARG && !soft_rst_r
        |=> cmd_argument_o == $past(wdata_i))
        else $error("argument register not updated");
    rwait_hold_a: assert property (rw_state_r == SHSC_RW_ACTIVE && !rw_clear
        && read_wait_en_r && !soft_rst_r && !(wr_ctrl && wdata_i[SHSC_CTL_SOFT_RST])
        |=> ##1 tx_line2_oe_r)
        else $error("read wait dropped before software release");
    byte_order_a: assert property (##1 xfer_byte_o == shsc_pick_byte($past(xfer_word_i),
        $past(xfer_idx_i), $past(xfer_half_i), $past(byte_order_sel_r)))
        else $error("byte order lane wrong");
    div_range_a: assert property (div_cnt_r <= div_top)
        else $error("prescaler counter out of range");
endmodule
`default_nettype wire

/* verification/shsc_card_model.sv */
// card side model: interrupt source on data line 1, read wait observer on line 2
`timescale 1ns/100ps
`default_nettype none
module shsc_card_model (
    input  wire logic clk_i,
    input  wire logic irq_req_i,
    input  wire logic line2_i,
    output var  logic line1_o,
    output var  logic wait_seen_o
);
    // line 1 idles high on its pull-up, card pulls it low to interrupt
    initial line1_o = 1'b1;
    always @(posedge clk_i) line1_o <= ~irq_req_i;
    always_comb wait_seen_o = ~line2_i;
endmodule
`default_nettype wire

/* verification/shsc_sdio_ctrl_tb.sv */
// self-checking bench for the sdio host control block
`timescale 1ns/100ps
`default_nettype none
module shsc_sdio_ctrl_tb;
    import shsc_pkg::*;
    logic        clk_sys_i, rstn_i, wr_i, rd_i, data_packet_done_i, multi_block_i;
    logic        last_block_i, multi_read_i, withdata_cmd_end_i, abort_rsp_end_i;
    logic        xfer_half_i, tx_data_line2_o, tx_data_line2_oe_o, card_clock_o;
    logic        clock_type_sel_o, block_soft_reset_o, card_irq_pending_o;
    logic        rx_data_line1_i, irq_req, line2, wait_seen;
    logic [31:0] addr_i, wdata_i, rdata_o, xfer_word_i, cmd_argument_o, d, v;
    logic [1:0]  xfer_idx_i;
    logic [7:0]  xfer_byte_o;
    int          fails, tests_run, i, k, r;

    shsc_sdio_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .data_packet_done_i(data_packet_done_i), .multi_block_i(multi_block_i),
        .last_block_i(last_block_i), .multi_read_i(multi_read_i),
        .withdata_cmd_end_i(withdata_cmd_end_i), .abort_rsp_end_i(abort_rsp_end_i),
        .xfer_word_i(xfer_word_i), .xfer_idx_i(xfer_idx_i), .xfer_half_i(xfer_half_i),
        .xfer_byte_o(xfer_byte_o), .rx_data_line1_i(rx_data_line1_i),
        .tx_data_line2_o(tx_data_line2_o), .tx_data_line2_oe_o(tx_data_line2_oe_o),
        .card_clock_o(card_clock_o), .clock_type_sel_o(clock_type_sel_o),
        .block_soft_reset_o(block_soft_reset_o), .cmd_argument_o(cmd_argument_o),
        .card_irq_pending_o(card_irq_pending_o));
    shsc_card_model card (.clk_i(clk_sys_i), .irq_req_i(irq_req), .line2_i(line2),
        .line1_o(rx_data_line1_i), .wait_seen_o(wait_seen));
    // line 2 has a pull-up
    assign line2 = tx_data_line2_oe_o ? tx_data_line2_o : 1'b1;

    always #12.5 clk_sys_i = ~clk_sys_i;

    task test_done();
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] x);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= x;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [31:0] a, output logic [31:0] x);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 x = rdata_o;
    endtask
    task pulse_done();
        @(posedge clk_sys_i) data_packet_done_i <= 1'b1;
        @(posedge clk_sys_i) data_packet_done_i <= 1'b0;
    endtask
    function automatic logic hit(input int s);
        return s ? tx_data_line2_oe_o === 1'b1 : card_irq_pending_o === 1'b1;
    endfunction
    // bounded wait; running out ends the run as a failure
    task wt(input int s);
        int n;
        n = 0;
        while (n < 40 && !hit(s)) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (n == 40) begin
            fails++;
            $display("ERROR %0t wait ran out", $time);
            test_done();
        end
    endtask
    task rises(output int c);
        logic p;
        c = 0;
        p = card_clock_o;
        repeat (16) begin
            @(posedge clk_sys_i);
            #1 if (card_clock_o === 1'b1 && p === 1'b0) c++;
            p = card_clock_o;
        end
    endtask
    function automatic logic [7:0] exp_byte(logic [31:0] w, logic [1:0] x, logic h, logic o);
        int lane;
        lane = h ? (o ? 1 - x[0] : x[0]) : (o ? 3 - x : x);
        return w[lane*8 +: 8];
    endfunction

    initial begin
        {clk_sys_i, rstn_i, wr_i, rd_i, data_packet_done_i, multi_block_i, last_block_i} = '0;
        {multi_read_i, withdata_cmd_end_i, abort_rsp_end_i, xfer_half_i, irq_req} = '0;
        {addr_i, wdata_i, xfer_word_i, xfer_idx_i} = '0;
        fails = 0;
        tests_run = 0;
        void'($urandom(4191));
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rd(SHSC_ADDR_PRESCALER, d); chk(d, 32'h1);
        rd(SHSC_ADDR_CMD_ARG, d); chk(d, 32'h0);
        rd(32'h5a00000c, d); chk(d, 32'h0);
        for (i = 0; i < 5; i++) begin
            v = i ? $urandom : 32'hffffffff;
            wr(SHSC_ADDR_CMD_ARG, v); chk(cmd_argument_o, v);
            rd(SHSC_ADDR_CMD_ARG, d); chk(d, v);
        end
        wr(SHSC_ADDR_HOST_CTRL, 32'h20); chk(clock_type_sel_o, 1);
        rises(r); chk(r, 0);
        wr(SHSC_ADDR_PRESCALER, 32'h3);
        wr(SHSC_ADDR_HOST_CTRL, 32'h1);
        rises(r); chk(r, 4);
        for (i = 0; i < 16; i++) begin
            if (i % 8 == 0) wr(SHSC_ADDR_HOST_CTRL, (i / 8) << 4 | 1);
            @(posedge clk_sys_i);
            v = $urandom;
            xfer_word_i <= v;
            xfer_idx_i <= i[1:0];
            xfer_half_i <= i[2];
            @(posedge clk_sys_i);
            #1 chk(xfer_byte_o, exp_byte(v, i[1:0], i[2], i[3]));
        end
        wr(SHSC_ADDR_PRESCALER, 32'h1);
        // card needs 74 card clocks, two system cycles each, before any command
        repeat (2 * 74) @(posedge clk_sys_i);
        irq_req = 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rd(SHSC_ADDR_SDIO_STAT, d); chk(d[0], 0);
        wr(SHSC_ADDR_HOST_CTRL, 32'h9);
        wt(0);
        irq_req = 1'b0;
        wr(SHSC_ADDR_SDIO_CFG, 32'h1);
        repeat (8) @(posedge clk_sys_i);
        wr(SHSC_ADDR_SDIO_STAT, 32'h1);
        irq_req = 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rd(SHSC_ADDR_SDIO_STAT, d); chk(d[2:0], 0);
        pulse_done();
        wt(0);
        rd(SHSC_ADDR_SDIO_STAT, d); chk(d[2], 1);
        irq_req = 1'b0;
        wr(SHSC_ADDR_HOST_CTRL, 32'h5);
        multi_read_i <= 1'b1;
        pulse_done();
        wt(1); chk(wait_seen, 1);
        repeat (10) @(posedge clk_sys_i);
        rd(SHSC_ADDR_SDIO_STAT, d); chk(d[1], 1);
        chk(wait_seen, 1);
        wr(SHSC_ADDR_SDIO_STAT, 32'h2);
        @(posedge clk_sys_i);
        #1 chk(tx_data_line2_oe_o, 0);
        wr(SHSC_ADDR_HOST_CTRL, 32'h1);
        pulse_done();
        repeat (20) @(posedge clk_sys_i);
        #1 chk(wait_seen, 0);
        // multi block windows: type 0, type 1, type 1 last block
        multi_block_i <= 1'b1;
        wr(SHSC_ADDR_HOST_CTRL, 32'h9);
        for (k = 0; k < 3; k++) begin
            irq_req = 1'b0;
            wr(SHSC_ADDR_SDIO_CFG, 32'h0);
            wr(SHSC_ADDR_SDIO_CFG, k ? 32'h3 : 32'h1);
            wr(SHSC_ADDR_SDIO_STAT, 32'h1);
            irq_req = 1'b1;
            last_block_i <= (k == 2);
            repeat (8) @(posedge clk_sys_i);
            pulse_done();
            wt(0);
            repeat (12) @(posedge clk_sys_i);
            rd(SHSC_ADDR_SDIO_STAT, d); chk(d[2], k == 2);
            if (k == 0) begin
                wr(SHSC_ADDR_SDIO_STAT, 32'h1);
                chk(card_irq_pending_o, 0);
                @(posedge clk_sys_i) abort_rsp_end_i <= 1'b1;
                @(posedge clk_sys_i) abort_rsp_end_i <= 1'b0;
                wt(0);
            end
        end
        @(posedge clk_sys_i) withdata_cmd_end_i <= 1'b1;
        @(posedge clk_sys_i) withdata_cmd_end_i <= 1'b0;
        rd(SHSC_ADDR_SDIO_STAT, d); chk(d[2], 0);
        wr(SHSC_ADDR_PRESCALER, 32'h7);
        wr(SHSC_ADDR_HOST_CTRL, 32'h131);
        chk(block_soft_reset_o, 1);
        rd(SHSC_ADDR_HOST_CTRL, d); chk(d, 32'h0);
        rd(SHSC_ADDR_PRESCALER, d); chk(d, 32'h1);
        chk(block_soft_reset_o, 0);
        test_done();
    end
endmodule
`default_nettype wire
